// File: rtl/cstc_defs.svh
// Purpose: named offsets, fields and reset values of the status block
// Assumes: 32-bit wishbone data, registers in the low byte
// Notes:   byte address is four times the register index
`ifndef CSTC_DEFS_SVH
`define CSTC_DEFS_SVH
// ==========================================================
// register map
`define CSTC_TMR_IDX      6'h05
`define CSTC_CPU_IDX      6'h06
// ==========================================================
// cpu status fields
`define CSTC_CPU_STK      5
`define CSTC_CPU_GLM      4
`define CSTC_CPU_TO       3
`define CSTC_CPU_PD       2
`define CSTC_CPU_POR      1
`define CSTC_CPU_BOR      0
`define CSTC_CPU_WMASK    8'h13
// ==========================================================
// timer control fields
`define CSTC_TMR_EDG      7
`define CSTC_TMR_CSE      6
`define CSTC_TMR_SRC      5
`define CSTC_TMR_PS_HI    4
`define CSTC_TMR_PS_LO    1
`define CSTC_TMR_WMASK    8'hFE
`define CSTC_TMR_RST      8'h00
// ==========================================================
// misc
`define CSTC_SP_TOP       4'hF
`define CSTC_SP_RST       4'h0
`define CSTC_PS_MAX       8'hFF
`define CSTC_NIRQ         8
`endif

// File: rtl/cstc_pkg.sv
// Purpose: shared types of the status block
// Assumes: nothing
// Notes:   constants live in cstc_defs.svh
`include "cstc_defs.svh"
package cstc_pkg;
	typedef logic [7:0] cstc_byte_t;
	typedef enum logic [1:0] {CSTC_SEL_NONE, CSTC_SEL_TMR,
		CSTC_SEL_CPU} cstc_sel_t;
	// prescale limit: ratio minus one, codes 1xxx saturate
	function automatic cstc_byte_t cstc_ps_limit(input logic [3:0] c);
		if (c[3]) begin
			return `CSTC_PS_MAX;
		end
		return 8'(({1'b0, `CSTC_PS_MAX} >> (4'h8 - c)) & 9'h0FF);
	endfunction
endpackage

// File: rtl/cstc_stack_mon.sv
// Purpose: stack pointer and stack space flag
// Assumes: push and pop are one-cycle pulses from the core
// Notes:   pointer wraps, overwriting the oldest entry
`timescale 1ns/1ns
`default_nettype none
`include "cstc_defs.svh"
module cstc_stack_mon
	import cstc_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       push_i,
	input  wire logic       pop_i,
	output logic      [3:0] stack_ptr_o,
	output logic            stack_space_o
);
	logic       locked_r;
	logic [3:0] sp_nxt;
	logic       lock_nxt;

	always_comb begin
		sp_nxt = stack_ptr_o;
		if (push_i && !pop_i) begin
			sp_nxt = stack_ptr_o + 4'h1;
		end else if (pop_i && !push_i) begin
			sp_nxt = stack_ptr_o - 4'h1;
		end
		// wrap on overflow locks the flag until reset
		lock_nxt = locked_r || (push_i && !pop_i &&
			stack_ptr_o == `CSTC_SP_TOP);
	end

	// ==========================================================
	// state
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stack_ptr_o   <= `CSTC_SP_RST;
			locked_r      <= 1'b0;
			stack_space_o <= 1'b1;
		end else begin
			stack_ptr_o   <= sp_nxt;
			locked_r      <= lock_nxt;
			stack_space_o <= !lock_nxt && sp_nxt != `CSTC_SP_TOP;
		end
	end

	property p_stk_full;
		@(posedge sys_clk_i) disable iff (rst_i)
		stack_ptr_o == `CSTC_SP_TOP |-> !stack_space_o;
	endproperty
	a_stk_full: assert property (p_stk_full)
		else $error("stack flag set at top pointer");

	property p_stk_lock;
		@(posedge sys_clk_i) disable iff (rst_i)
		locked_r |-> !stack_space_o [*8];
	endproperty
	a_stk_lock: assert property (p_stk_lock)
		else $error("stack flag set after overflow");
endmodule
`default_nettype wire

// File: rtl/cstc_timer_pre.sv
// Purpose: pin edge detection and timer prescaler
// Assumes: pins are asynchronous, tcy pulse is on sys_clk_i
// Notes:   two-stage synchronisers add two cycles of latency
`timescale 1ns/1ns
`default_nettype none
`include "cstc_defs.svh"
module cstc_timer_pre
	import cstc_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       irq_pin_i,
	input  wire logic       tclk_pin_i,
	input  wire logic       tcy_i,
	input  wire cstc_byte_t ctl_i,
	output logic            ext_irq_set_o,
	output logic            ext_clk_flag_o,
	output logic            timer_inc_o
);
	logic [2:0] irq_s_r;
	logic [2:0] tclk_s_r;
	cstc_byte_t pre_r;
	logic       irq_edge;
	logic       clk_edge;
	logic       src_evt;

	// ==========================================================
	// synchronisers, third stage only feeds the edge compare
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_s_r  <= 3'h0;
			tclk_s_r <= 3'h0;
		end else begin
			irq_s_r  <= {irq_s_r[1:0], irq_pin_i};
			tclk_s_r <= {tclk_s_r[1:0], tclk_pin_i};
		end
	end

	always_comb begin
		irq_edge = ctl_i[`CSTC_TMR_EDG] ? (irq_s_r[1] && !irq_s_r[2])
			: (!irq_s_r[1] && irq_s_r[2]);
		clk_edge = ctl_i[`CSTC_TMR_CSE] ? (tclk_s_r[1] && !tclk_s_r[2])
			: (!tclk_s_r[1] && tclk_s_r[2]);
		src_evt = ctl_i[`CSTC_TMR_SRC] ? tcy_i : clk_edge;
	end

	// ==========================================================
	// prescaler
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_r         <= 8'h00;
			timer_inc_o   <= 1'b0;
			ext_irq_set_o <= 1'b0;
			ext_clk_flag_o <= 1'b0;
		end else begin
			ext_irq_set_o  <= irq_edge;
			ext_clk_flag_o <= !ctl_i[`CSTC_TMR_SRC] && clk_edge;
			timer_inc_o    <= 1'b0;
			if (src_evt) begin
				if (pre_r >= cstc_ps_limit(
					ctl_i[`CSTC_TMR_PS_HI:`CSTC_TMR_PS_LO])) begin
					pre_r       <= 8'h00;
					timer_inc_o <= 1'b1;
				end else begin
					pre_r <= pre_r + 8'h01;
				end
			end
		end
	end

	property p_pre_bound;
		@(posedge sys_clk_i) disable iff (rst_i)
		timer_inc_o |-> $past(src_evt) && $past(pre_r) >=
			cstc_ps_limit($past(ctl_i[`CSTC_TMR_PS_HI:`CSTC_TMR_PS_LO]));
	endproperty
	a_pre_bound: assert property (p_pre_bound)
		else $error("timer tick off prescale ratio");
endmodule
`default_nettype wire

// File: rtl/cstc_regs.sv
// Purpose: cpu status and timer control registers on wishbone
// Assumes: core events are one-cycle pulses on sys_clk_i
// Notes:   reset causes are sampled at the first edge after release
//
// Functional notes
// - the stack space flag clears when the pointer is F or wraps.
// - after an overflow wrap the stack space flag stays clear until reset.
// - timeout, power-down and stack flags ignore bus writes.
// - a set global mask blocks all interrupts.
// - with the mask clear only enabled sources interrupt.
// - timeout flag sets on power-up, clear or sleep, clears on timeout.
// - power-down flag sets on power-up or clear, clears on sleep.
// - power-on flag clears on power-on reset, software sets it.
// - brown-out flag clears on brown-out reset when enabled.
// - the flags together tell power-on, master and watchdog resets.
// - edge select bit picks rising or falling irq pin edge.
// - clock edge bit picks the external timer clock edge.
// - source bit picks instruction cycle or external clock.
// - prescale code gives ratio two to the code, 1xxx gives 256.
// - unimplemented bits read as zero.
// - every reset zeroes the stack pointer and sets the stack flag.
`timescale 1ns/1ns
`default_nettype none
`include "cstc_defs.svh"
module cstc_regs
	import cstc_pkg::*;
(
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic            [7:0] wb_adr_i,
	input  wire logic            [3:0] wb_sel_i,
	input  wire logic           [31:0] wb_dat_i,
	output logic                [31:0] wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic                  push_i,
	input  wire logic                  pop_i,
	input  wire logic                  watchdog_clear_instr_i,
	input  wire logic                  sleep_instr_i,
	input  wire logic                  wdog_timeout_i,
	input  wire logic                  por_cause_i,
	input  wire logic                  wdt_cause_i,
	input  wire logic                  bor_cause_i,
	input  wire logic                  brownout_detect_enable_i,
	input  wire logic [`CSTC_NIRQ-1:0] irq_req_i,
	input  wire logic [`CSTC_NIRQ-1:0] irq_en_i,
	input  wire logic                  instr_cycle_clock_i,
	input  wire logic                  ext_irq_pin_i,
	input  wire logic                  timer_ext_clk_pin_i,
	output logic                       irq_take_o,
	output logic                       ext_irq_set_o,
	output logic                       timer_ext_clk_flag_o,
	output logic                       timer_inc_o,
	output logic                 [3:0] stack_ptr_o
);
	cstc_byte_t tmr_r;
	logic       glm_r;
	logic       to_r;
	logic       pd_r;
	logic       por_r;
	logic       bor_r;
	logic       rel_r;
	logic       stk_flag;
	logic       req;
	logic       wr_en;
	cstc_sel_t  sel;
	cstc_byte_t cpu_rd;

	// ==========================================================
	// submodules
	cstc_stack_mon u_stack (
		.sys_clk_i     (sys_clk_i),
		.rst_i         (rst_i),
		.push_i        (push_i),
		.pop_i         (pop_i),
		.stack_ptr_o   (stack_ptr_o),
		.stack_space_o (stk_flag)
	);

	cstc_timer_pre u_timer (
		.sys_clk_i      (sys_clk_i),
		.rst_i          (rst_i),
		.irq_pin_i      (ext_irq_pin_i),
		.tclk_pin_i     (timer_ext_clk_pin_i),
		.tcy_i          (instr_cycle_clock_i),
		.ctl_i          (tmr_r),
		.ext_irq_set_o  (ext_irq_set_o),
		.ext_clk_flag_o (timer_ext_clk_flag_o),
		.timer_inc_o    (timer_inc_o)
	);

	// ==========================================================
	// bus decode
	always_comb begin
		req = wb_cyc_i && wb_stb_i;
		// write lands on the edge where the master sees ack
		wr_en = req && wb_we_i && wb_ack_o && wb_sel_i[0];
		unique case (wb_adr_i[7:2])
			`CSTC_TMR_IDX: sel = CSTC_SEL_TMR;
			`CSTC_CPU_IDX: sel = CSTC_SEL_CPU;
			default:       sel = CSTC_SEL_NONE;
		endcase
		cpu_rd = 8'h00;
		cpu_rd[`CSTC_CPU_STK] = stk_flag;
		cpu_rd[`CSTC_CPU_GLM] = glm_r;
		cpu_rd[`CSTC_CPU_TO]  = to_r;
		cpu_rd[`CSTC_CPU_PD]  = pd_r;
		cpu_rd[`CSTC_CPU_POR] = por_r;
		cpu_rd[`CSTC_CPU_BOR] = bor_r;
	end

	// ==========================================================
	// wishbone answer, one wait state, unmapped reads give zero
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
			if (req && !wb_ack_o) begin
				unique case (sel)
					CSTC_SEL_TMR:
						wb_dat_o <= {24'h000000,
							tmr_r & `CSTC_TMR_WMASK};
					CSTC_SEL_CPU:
						wb_dat_o <= {24'h000000, cpu_rd};
					CSTC_SEL_NONE:
						wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// timer control, bit 0 is never stored
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tmr_r <= `CSTC_TMR_RST;
		end else if (wr_en && sel == CSTC_SEL_TMR) begin
			tmr_r <= wb_dat_i[7:0] & `CSTC_TMR_WMASK;
		end
	end

	// ==========================================================
	// global mask, software only
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			glm_r <= 1'b1;
		end else if (wr_en && sel == CSTC_SEL_CPU) begin
			glm_r <= wb_dat_i[`CSTC_CPU_GLM];
		end
	end

	// ==========================================================
	// reset cause capture: flops reset to constants, so the cause
	// is applied one edge after release instead of during reset
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rel_r <= 1'b1;
		end else begin
			rel_r <= 1'b0;
		end
	end

	// ==========================================================
	// timeout and power-down, hardware only
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			to_r <= 1'b1;
			pd_r <= 1'b1;
		end else begin
			if (watchdog_clear_instr_i) begin
				to_r <= 1'b1;
				pd_r <= 1'b1;
			end else if (sleep_instr_i) begin
				to_r <= 1'b1;
				pd_r <= 1'b0;
			end
			// a timeout outranks a clear in the same cycle
			if (wdog_timeout_i || (rel_r && wdt_cause_i)) begin
				to_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// power-on and brown-out flags, software sets, hardware clears
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			por_r <= 1'b1;
			bor_r <= 1'b1;
		end else begin
			if (wr_en && sel == CSTC_SEL_CPU) begin
				por_r <= wb_dat_i[`CSTC_CPU_POR];
				bor_r <= wb_dat_i[`CSTC_CPU_BOR];
			end
			// hardware clear wins over a same-cycle write
			if (rel_r && por_cause_i) begin
				por_r <= 1'b0;
			end
			if (rel_r && bor_cause_i && brownout_detect_enable_i) begin
				bor_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// interrupt gate
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_take_o <= 1'b0;
		end else begin
			irq_take_o <= !glm_r && |(irq_req_i & irq_en_i);
		end
	end

	// ==========================================================
	// checks
	property p_irq_block;
		@(posedge sys_clk_i) disable iff (rst_i)
		glm_r |=> !irq_take_o;
	endproperty
	a_irq_block: assert property (p_irq_block)
		else $error("interrupt passed the global mask");

	property p_irq_en;
		@(posedge sys_clk_i) disable iff (rst_i)
		irq_take_o |-> $past(|(irq_req_i & irq_en_i));
	endproperty
	a_irq_en: assert property (p_irq_en)
		else $error("interrupt from a disabled source");

	property p_ro_flags;
		@(posedge sys_clk_i) disable iff (rst_i)
		wr_en && sel == CSTC_SEL_CPU && !watchdog_clear_instr_i &&
		!sleep_instr_i && !wdog_timeout_i && !rel_r
		|=> $stable(to_r) && $stable(pd_r);
	endproperty
	a_ro_flags: assert property (p_ro_flags)
		else $error("bus write changed a read-only flag");

	property p_to_clear;
		@(posedge sys_clk_i) disable iff (rst_i)
		wdog_timeout_i |=> !to_r;
	endproperty
	a_to_clear: assert property (p_to_clear)
		else $error("timeout flag not cleared");

	property p_pd_sleep;
		@(posedge sys_clk_i) disable iff (rst_i)
		sleep_instr_i && !watchdog_clear_instr_i |=> !pd_r &&
			(to_r || $past(wdog_timeout_i));
	endproperty
	a_pd_sleep: assert property (p_pd_sleep)
		else $error("sleep did not set flags");

	property p_por;
		@(posedge sys_clk_i) disable iff (rst_i)
		rel_r && por_cause_i |=> !por_r;
	endproperty
	a_por: assert property (p_por)
		else $error("power-on flag not cleared");

	property p_bor;
		@(posedge sys_clk_i) disable iff (rst_i)
		rel_r && bor_cause_i && brownout_detect_enable_i |=> !bor_r;
	endproperty
	a_bor: assert property (p_bor)
		else $error("brown-out flag not cleared");

	property p_unimpl;
		@(posedge sys_clk_i) disable iff (rst_i)
		req && !wb_ack_o && sel != CSTC_SEL_NONE |=>
			wb_dat_o[31:8] == 24'h000000 &&
			($past(sel) == CSTC_SEL_TMR ? !wb_dat_o[0]
			: wb_dat_o[7:6] == 2'b00);
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("unimplemented bit read as one");

	property p_ack_pulse;
		@(posedge sys_clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// File: dv/cstc_regs_tb.sv
// Purpose: self-checking bench of the status and timer control block
// Assumes: classic wishbone, one clock, core events as one-cycle pulses
// Notes:   brown-out cause is only driven while detection is enabled
`timescale 1ns/1ns
`default_nettype none
`include "cstc_defs.svh"
module cstc_regs_tb
	import cstc_pkg::*;
;
// ==========================================================
// signals
localparam logic [5:0] cpu_a = `CSTC_CPU_IDX;
localparam logic [5:0] tmr_a = `CSTC_TMR_IDX;
logic        clk, rst, cyc, stb, we, ipin, cpin, por_c, wdt_c, bor_c, brownout_detect_enable;
logic  [7:0] adr, req, en;
logic  [3:0] sel, sp, code;
logic [31:0] dat, dat_o;
logic  [5:0] ev;
logic        ack, take, iset, cflag, inc;
int          tests_run = 0, miscompares = 0, cycles = 0;
int          n_irq = 0, n_ext = 0, n_inc = 0, di, de, dn;
cstc_byte_t  cpu_m, t_m, q, w;
logic  [3:0] rc [4] = '{4'b1000, 4'b0100, 4'b0011, 4'b0000};
logic  [5:0] pe [4] = '{6'h08, 6'h10, 6'h04, 6'h10};
logic  [1:0] px [4] = '{2'b10, 2'b00, 2'b11, 2'b01};
// op 0 stands for a device reset between stack moves
logic  [5:0] sop [10] = '{2, 1, 1, 2, 2, 0, 2, 1, 2, 2};
logic  [3:0] ssp [10] = '{14, 15, 0, 15, 14, 0, 15, 0, 15, 14};
logic        sfl [10] = '{1, 0, 0, 0, 0, 1, 0, 0, 0, 0};

cstc_regs i_cstc_regs (
	.sys_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
	.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
	.wb_dat_o(dat_o), .wb_ack_o(ack), .push_i(ev[0]), .pop_i(ev[1]),
	.watchdog_clear_instr_i(ev[2]), .sleep_instr_i(ev[3]),
	.wdog_timeout_i(ev[4]), .por_cause_i(por_c), .wdt_cause_i(wdt_c),
	.bor_cause_i(bor_c), .brownout_detect_enable_i(brownout_detect_enable),
	.irq_req_i(req), .irq_en_i(en), .instr_cycle_clock_i(ev[5]),
	.ext_irq_pin_i(ipin), .timer_ext_clk_pin_i(cpin), .irq_take_o(take),
	.ext_irq_set_o(iset), .timer_ext_clk_flag_o(cflag),
	.timer_inc_o(inc), .stack_ptr_o(sp));

// ==========================================================
// clock, pulse counters, timeout
initial begin
	clk = 1'b0;
	forever #10 clk = ~clk;
end
// counted on the falling edge so the tests never race the counters
always @(negedge clk) begin
	n_irq += (iset === 1'b1) ? 1 : 0;
	n_ext += (cflag === 1'b1) ? 1 : 0;
	n_inc += (inc === 1'b1) ? 1 : 0;
end
always @(posedge clk) begin
	cycles++;
	if (cycles == 50000) begin
		miscompares++;
		$display("[ERR] %0t run timed out", $time);
		summarize();
	end
end

// ==========================================================
// expectations
function automatic cstc_byte_t exp_cpu(cstc_byte_t c, cstc_byte_t v);
	return (c & 8'hEC) | (v & 8'h13);
endfunction
function automatic cstc_byte_t exp_rst(logic [3:0] c);
	return {2'b00, 2'b11, ~c[2], 1'b1, ~c[3], ~(c[1] & c[0])};
endfunction
function automatic logic exp_take(cstc_byte_t m, logic [7:0] r, e);
	return !m[4] && (|(r & e));
endfunction
function automatic int ratio(logic [3:0] c);
	return c[3] ? 256 : (1 << c);
endfunction

// ==========================================================
// tasks
task automatic check(input logic [31:0] got, exp, input string what);
	tests_run++;
	if (got !== exp) begin
		miscompares++;
		$display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
	end
endtask
task automatic wb(input logic wr_en, input logic [5:0] idx,
	input cstc_byte_t d, input logic [3:0] s, output cstc_byte_t r);
	int n;
	n = 0;
	@(posedge clk);
	cyc <= 1'b1;
	stb <= 1'b1;
	we <= wr_en;
	adr <= {idx, 2'b00};
	sel <= s;
	dat <= {24'h000000, d};
	forever begin
		@(posedge clk);
		if (ack === 1'b1) break;
		n++;
		if (n > 50) begin
			miscompares++;
			break;
		end
	end
	r = dat_o[7:0];
	cyc <= 1'b0;
	stb <= 1'b0;
	we <= 1'b0;
endtask
task automatic wr(input logic [5:0] idx, input cstc_byte_t d);
	cstc_byte_t r;
	wb(1'b1, idx, d, 4'hF, r);
endtask
task automatic rd(input logic [5:0] idx, output cstc_byte_t r);
	wb(1'b0, idx, 8'h00, 4'hF, r);
endtask
task automatic do_reset(input logic [3:0] c, input int n);
	@(posedge clk);
	rst <= 1'b1;
	{por_c, wdt_c, bor_c, brownout_detect_enable} <= c;
	repeat (n) @(posedge clk);
	rst <= 1'b0;
	repeat (3) @(posedge clk);
	{por_c, wdt_c, bor_c} <= 3'b000;
endtask
task automatic pulse(input logic [5:0] v);
	@(posedge clk);
	ev <= v;
	@(posedge clk);
	ev <= 6'h00;
	@(posedge clk);
endtask
task automatic pin(input logic irq, lvl);
	int a, b, c;
	{a, b, c} = {n_irq, n_ext, n_inc};
	@(posedge clk);
	if (irq) ipin <= lvl;
	else cpin <= lvl;
	repeat (8) @(posedge clk);
	{di, de, dn} = {n_irq - a, n_ext - b, n_inc - c};
endtask
task automatic tcy_n(input int k);
	int c;
	c = n_inc;
	repeat (k) pulse(6'h20);
	repeat (4) @(posedge clk);
	dn = n_inc - c;
endtask
task automatic done(input string s);
	$display("test %s done", s);
endtask
task automatic summarize();
	$display("checks %0d mismatches %0d", tests_run, miscompares);
	if (miscompares == 0 && tests_run > 0) begin
		$display("Test passed");
	end else begin
		$display("Test failed");
	end
	$finish;
endtask

// ==========================================================
// main sequence
initial begin
	{rst, cyc, stb, we, ipin, cpin, por_c, wdt_c, bor_c, brownout_detect_enable} = 10'h200;
	{adr, req, en, sel, dat, ev} = '0;
	void'($urandom(32'h5C81910E));
	do_reset(4'b0000, 12);
	foreach (rc[i]) begin
		do_reset(rc[i], 3);
		rd(cpu_a, q);
		check(q, exp_rst(rc[i]), "cpu reset");
		rd(tmr_a, q);
		check(q, 8'h00, "tmr reset");
	end
	done("reset causes");
	cpu_m = 8'h3F;
	repeat (8) begin
		w = 8'($urandom);
		wr(cpu_a, w);
		cpu_m = exp_cpu(cpu_m, w);
		rd(cpu_a, q);
		check(q, cpu_m, "cpu write");
		t_m = 8'($urandom);
		wr(tmr_a, t_m);
		t_m &= 8'hFE;
		rd(tmr_a, q);
		check(q, t_m, "tmr write");
	end
	wb(1'b1, tmr_a, ~t_m, 4'hE, q);
	wr(6'h00, 8'hFF);
	rd(6'h00, q);
	check(q, 8'h00, "unmapped");
	rd(tmr_a, q);
	check(q, t_m, "tmr kept");
	rd(cpu_a, q);
	check(q, cpu_m, "cpu kept");
	done("register access");
	foreach (pe[i]) begin
		pulse(pe[i]);
		cpu_m[3:2] = px[i];
		w = 8'($urandom);
		wr(cpu_a, w);
		cpu_m = exp_cpu(cpu_m, w);
		rd(cpu_a, q);
		check(q, cpu_m, "power flags");
	end
	done("power flags");
	for (int i = 0; i < 12; i++) begin
		if (i < 2 || i == 6) begin
			cpu_m = exp_cpu(cpu_m, {3'b000, i < 2, 4'h3});
			wr(cpu_a, cpu_m);
		end
		@(posedge clk);
		req <= (i < 2 || i == 6) ? 8'hFF : 8'($urandom);
		en <= (i == 6) ? 8'h00 : (i < 2) ? 8'hFF : 8'($urandom);
		repeat (2) @(posedge clk);
		check(take, exp_take(cpu_m, req, en), "irq take");
	end
	{req, en} <= 16'h0000;
	done("interrupt gating");
	repeat (15) pulse(6'h01);
	rd(cpu_a, q);
	check({sp, q[5]}, 5'h1E, "stack top");
	foreach (sop[i]) begin
		if (sop[i] == 6'h00) do_reset(4'b0000, 3);
		else pulse(sop[i]);
		rd(cpu_a, q);
		check({sp, q[5]}, {ssp[i], sfl[i]}, "stack");
	end
	done("stack");
	for (int s = 0; s < 2; s++) begin
		wr(tmr_a, {s[0], 7'h00});
		pin(1'b1, 1'b1);
		check(di, s, "irq rise");
		pin(1'b1, 1'b0);
		check(di, 1 - s, "irq fall");
		wr(tmr_a, {1'b0, s[0], 6'h00});
		pin(1'b0, 1'b1);
		check(de, s, "clk rise flag");
		check(dn, s, "clk rise count");
		pin(1'b0, 1'b0);
		check(de, 1 - s, "clk fall flag");
		check(dn, 1 - s, "clk fall count");
		tcy_n(1);
		check(dn, 0, "tcy ignored");
	end
	wr(tmr_a, 8'h60);
	pin(1'b0, 1'b1);
	pin(1'b0, 1'b0);
	check(de, 0, "pin flag ignored");
	check(dn, 0, "pin count ignored");
	done("edges and source");
	for (int k = 0; k < 10; k++) begin
		code = (k < 8) ? 4'(k) : 4'(8 + $urandom_range(7));
		wr(tmr_a, {3'b001, code, 1'b0});
		tcy_n(2 * ratio(code));
		check(dn, 2, "prescale");
	end
	done("prescale");
	summarize();
end
endmodule
`default_nettype wire
